// File: dv/rhg_acq_model.sv
// Acquisition engine source and stalling header sink for the generator
`timescale 1ns/1ps
module rhg_acq_model (
  input wire logic aclk,
  output logic rec_start,
  output logic rec_end,
  output logic [7:0] rec_chan,
  output logic rec_wide,
  output logic [31:0] sample_period,
  output logic [63:0] trigger_time_ticks,
  output logic [63:0] rec_start_ofs,
  output logic [31:0] rec_len_bytes,
  output logic [15:0] ts_reset_cnt,
  output logic range_hit,
  output logic [2:0] fifo_fill,
  output logic lost_whole,
  output logic lost_head,
  output logic lost_mid,
  output logic lost_tail,
  input wire logic [31:0] hdr_data,
  input wire logic hdr_valid,
  input wire logic hdr_last,
  output logic hdr_ready
);
  logic [31:0] words [0:127]; // Captured header words
  logic lasts [0:127]; // Captured last flags
  int n = 0; // Words taken so far
  int cyc = 0; // Free cycle count for the stall pattern
  // Quiet source at time zero
  initial begin
    {rec_start, rec_end, rec_chan, rec_wide, sample_period, trigger_time_ticks} = '0;
    {rec_start_ofs, rec_len_bytes, ts_reset_cnt, range_hit, fifo_fill} = '0;
    {lost_whole, lost_head, lost_mid, lost_tail} = '0;
  end
  // One record: start, one flagged cycle, calm cycle, end with field levels
  task run(input logic [7:0] k, input logic rng, input logic [2:0] pk,
           input logic [3:0] lost, input logic wide, input logic [7:0] chan);
    @(posedge aclk);
    rec_start <= 1'b1;
    fifo_fill <= 3'h0;
    rec_chan <= chan;
    rec_wide <= wide;
    sample_period <= 32'h00000190 + k;
    trigger_time_ticks <= {32'h00000002, 24'h000000, k};
    rec_start_ofs <= 64'hFFFFFFFFFFFFFF9C - k;
    rec_len_bytes <= 32'h00000400 + k;
    ts_reset_cnt <= 16'h0003 + k;
    @(posedge aclk);
    rec_start <= 1'b0;
    fifo_fill <= pk;
    range_hit <= rng;
    {lost_tail, lost_mid, lost_head, lost_whole} <= lost;
    @(posedge aclk);
    fifo_fill <= 3'h1;
    range_hit <= 1'b0;
    {lost_tail, lost_mid, lost_head, lost_whole} <= 4'h0;
    @(posedge aclk);
    rec_end <= 1'b1;
    @(posedge aclk);
    rec_end <= 1'b0;
  endtask
  // DMA sink, stalls one cycle in three
  always @(posedge aclk) begin
    if (hdr_valid && hdr_ready) begin
      words[n] <= hdr_data;
      lasts[n] <= hdr_last;
      n <= n + 1;
    end
    cyc <= cyc + 1;
    hdr_ready <= (cyc % 3) != 0;
  end
endmodule

// File: dv/testbench.sv
// Self-checking testbench for the record header generator
`timescale 1ns/1ps
module testbench;
  import rhg_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, hdr_data, sample_period, rec_len_bytes;
  logic hdr_valid, hdr_last, hdr_ready, rec_start, rec_end, rec_wide, range_hit;
  logic lost_whole, lost_head, lost_mid, lost_tail;
  logic [7:0] rec_chan;
  logic [63:0] trigger_time_ticks, rec_start_ofs;
  logic [15:0] ts_reset_cnt;
  logic [2:0] fifo_fill;
  int mismatches = 0;
  int tests_run = 0;
  int k;
  logic [7:0] tag = 8'h5A; // Host unit tag
  logic [31:0] serial = 32'h00001234; // Arbitrary serial value
  logic [15:0] gpv = 16'hBEEF; // General vector
  // 20 MHz clock
  always #25 aclk = ~aclk;
  rhg_top u_rhg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rec_start, .rec_end, .rec_chan, .rec_wide,
    .sample_period, .trigger_time_ticks, .rec_start_ofs, .rec_len_bytes, .ts_reset_cnt,
    .range_hit, .fifo_fill, .lost_whole, .lost_head, .lost_mid, .lost_tail, .hdr_data,
    .hdr_valid, .hdr_last, .hdr_ready);
  rhg_acq_model u_rhg_acq_model (.aclk, .rec_start, .rec_end, .rec_chan, .rec_wide,
    .sample_period, .trigger_time_ticks, .rec_start_ofs, .rec_len_bytes, .ts_reset_cnt,
    .range_hit, .fifo_fill, .lost_whole, .lost_head, .lost_mid, .lost_tail, .hdr_data,
    .hdr_valid, .hdr_last, .hdr_ready);
  // Verdict and end of run
  task finish_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One comparison
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Wait limit used up
  task hang(input string what);
    mismatches++;
    $display("MISMATCH at %0t: no %s", $time, what);
    finish_test;
  endtask
  // Register write, address and data offered together
  task axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
        chk(32'(s_axi_bresp), 32'(er), "write response");
        @(posedge aclk);
      end
    end
    if (!done) hang("write response");
  endtask
  // Register read
  task axi_rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
        chk(s_axi_rdata, ed, "read data");
        chk(32'(s_axi_rresp), 32'(er), "read response");
        @(posedge aclk);
      end
    end
    if (!done) hang("read data");
  endtask
  // Wait for the ten words of record n and compare them
  task hdr_check(input int n, input logic [7:0] st, input logic [7:0] ch, input logic wide);
    logic [31:0] e [0:9];
    int i;
    e[0] = {(wide ? FMT_S32 : FMT_S16), ch, tag, st};
    e[1] = serial;
    e[2] = 32'(n);
    e[3] = 32'h00000190 + 32'(n);
    e[4] = 32'(n);
    e[5] = 32'h00000002;
    e[6] = 32'hFFFFFF9C - 32'(n);
    e[7] = 32'hFFFFFFFF;
    e[8] = 32'h00000400 + 32'(n);
    e[9] = {16'h0003 + n[15:0], gpv};
    for (i = 0; i < 400 && u_rhg_acq_model.n < 10 * (n + 1); i++) @(posedge aclk);
    if (u_rhg_acq_model.n < 10 * (n + 1)) hang("header");
    for (i = 0; i < 10; i++) begin
      chk(u_rhg_acq_model.words[10 * n + i], e[i], "header word");
      chk(32'(u_rhg_acq_model.lasts[10 * n + i]), 32'(i == 9), "last flag");
    end
    $display("Test record %0d done", n);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADR_CTRL, 32'(RST_TAG), RESP_OKAY);
    axi_rd(ADR_SERIAL, RST_SERIAL, RESP_OKAY);
    axi_rd(ADR_RECNUM, 32'h00000000, RESP_OKAY);
    axi_rd(ADR_GPV, 32'(RST_GPV), RESP_OKAY);
    axi_rd(6'h14, 32'h00000000, RESP_SLVERR);
    axi_wr(6'h14, 32'h00000000, RESP_SLVERR);
    axi_wr(ADR_CTRL, 32'(tag), RESP_OKAY);
    axi_wr(ADR_SERIAL, serial, RESP_OKAY);
    axi_wr(ADR_GPV, 32'(gpv), RESP_OKAY);
    axi_wr(ADR_RECNUM, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(ADR_CTRL, 32'(tag), RESP_OKAY);
    axi_rd(ADR_RECNUM, 32'h00000000, RESP_OKAY);
    $display("Test registers done");
    u_rhg_acq_model.run(8'h00, 1'b1, 3'h5, 4'h4, 1'b0, 8'h01);
    hdr_check(0, 8'hD4, 8'h01, 1'b0);
    // Each lost kind alone, range flag cleared, fill max from 7 down
    for (k = 1; k < 5; k++) begin
      u_rhg_acq_model.run(8'(k), 1'b0, 3'(8 - k), 4'(1 << (k - 1)), k[0], 8'(8'h10 + k));
      hdr_check(k, {1'b0, 3'(8 - k), 4'(1 << (k - 1))}, 8'(8'h10 + k), k[0]);
    end
    axi_rd(ADR_RECNUM, 32'h00000005, RESP_OKAY);
    axi_rd(ADR_STAT, 32'h00000000, RESP_OKAY);
    // End refused while header 5 drains, so the next record stays open
    u_rhg_acq_model.run(8'h05, 1'b0, 3'h2, 4'h0, 1'b0, 8'h02);
    u_rhg_acq_model.run(8'h06, 1'b0, 3'h2, 4'h0, 1'b0, 8'h02);
    hdr_check(5, 8'h20, 8'h02, 1'b0);
    axi_rd(ADR_STAT, 32'h00000005, RESP_OKAY);
    axi_wr(ADR_STAT, 32'h00000000, RESP_OKAY);
    axi_rd(ADR_STAT, 32'h00000001, RESP_OKAY);
    // Second end closes the open record with flags of both runs
    u_rhg_acq_model.run(8'h06, 1'b0, 3'h2, 4'h0, 1'b0, 8'h02);
    hdr_check(6, 8'h20, 8'h02, 1'b0);
    axi_rd(ADR_RECNUM, 32'h00000007, RESP_OKAY);
    axi_rd(ADR_STAT, 32'h00000000, RESP_OKAY);
    $display("Test drop done");
    finish_test;
  end
endmodule

// File: hdl/rhg_pkg.sv
// Package of constants for the record header generator
package rhg_pkg;
  // Header geometry
  localparam int unsigned HDR_BYTES = 40;
  localparam int unsigned HDR_WORDS = 10;
  // Byte offsets of fields inside the header
  localparam int unsigned OFS_STATUS = 0;
  localparam int unsigned OFS_TAG = 1;
  localparam int unsigned OFS_CHAN = 2;
  localparam int unsigned OFS_FMT = 3;
  localparam int unsigned OFS_SERIAL = 4;
  localparam int unsigned OFS_RECNUM = 8;
  localparam int unsigned OFS_PERIOD = 12;
  localparam int unsigned OFS_TTIME = 16;
  localparam int unsigned OFS_START = 24;
  localparam int unsigned OFS_LEN = 32;
  localparam int unsigned OFS_GPV = 36;
  localparam int unsigned OFS_TSRST = 38;
  // Status bit positions
  localparam int unsigned ST_RANGE = 7;
  localparam int unsigned ST_FILL_HI = 6;
  localparam int unsigned ST_FILL_LO = 4;
  localparam int unsigned ST_LOST_REC = 0;
  localparam int unsigned ST_LOST_HEAD = 1;
  localparam int unsigned ST_LOST_MID = 2;
  localparam int unsigned ST_LOST_TAIL = 3;
  // Sample encodings
  localparam logic [7:0] FMT_S16 = 8'h00;
  localparam logic [7:0] FMT_S32 = 8'h01;
  // Register byte addresses
  localparam logic [5:0] ADR_CTRL = 6'h00;
  localparam logic [5:0] ADR_SERIAL = 6'h04;
  localparam logic [5:0] ADR_RECNUM = 6'h08;
  localparam logic [5:0] ADR_GPV = 6'h0C;
  localparam logic [5:0] ADR_STAT = 6'h10;
  // Reset values
  localparam logic [7:0] RST_TAG = 8'h00;
  localparam logic [31:0] RST_SERIAL = 32'h00000001;
  localparam logic [15:0] RST_GPV = 16'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Record state
  typedef enum logic [0:0] {
    RHG_IDLE = 1'b0,
    RHG_REC = 1'b1
  } rhg_state_t;
endpackage

// File: hdl/rhg_top.sv
// Record header generator with AXI4-Lite control registers
// Function
// R1: Status, tag, channel, encoding bytes first
// R2: Serial number field, numeric part, 32-bit
// R3: Record count from power-up, 32-bit
// R4: Signed sample period in 25 ps
// R5: Trigger time 64-bit in 25 ps
// R6: Signed trigger-to-start offset, 25 ps
// R7: Record length field, 32-bit, in bytes
// R8: General vector then timestamp reset count
// R9: Bit 7 flags any range violation
// R10: Bits 6-4 give fill in eighths
// R11: Fill field keeps record maximum
// R12: Bits 3-0 report overflow losses
// R13: Bit 0 marks wholly lost record
// R14: Bit 1 marks missing record start
// R15: Bit 2 middle loss, bit 3 tail
// R16: Encoding 0 is 16-bit, 1 32-bit
// R17: Low channel numbers are physical inputs
// R18: Host programs tag, copied into headers
// R19: Header is exactly forty bytes
// R20: Header emitted per masked record before memory; a record whose end arrives while busy_reg is set shares the next header
// R21: Packed little-endian fields, no padding
// R22: Flags cleared at start, accumulated to end; a start arriving in RHG_REC does not clear them
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module rhg_top
  import rhg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Acquisition engine events
  input wire logic rec_start,
  input wire logic rec_end,
  input wire logic [7:0] rec_chan,
  input wire logic rec_wide,
  input wire logic [31:0] sample_period,
  input wire logic [63:0] trigger_time_ticks,
  input wire logic [63:0] rec_start_ofs,
  input wire logic [31:0] rec_len_bytes,
  input wire logic [15:0] ts_reset_cnt,
  input wire logic range_hit,
  input wire logic [2:0] fifo_fill,
  input wire logic lost_whole,
  input wire logic lost_head,
  input wire logic lost_mid,
  input wire logic lost_tail,
  // Header word stream, 32-bit little-endian words
  output logic [31:0] hdr_data,
  output logic hdr_valid,
  output logic hdr_last,
  input wire logic hdr_ready
);

  // Software registers
  logic [7:0] unit_tag_byte_reg;
  logic [31:0] serial_reg;
  logic [15:0] gpv_reg;
  logic [31:0] recnum_reg;
  // Record accumulation
  rhg_state_t state_reg;
  logic range_reg;
  logic [2:0] fill_reg;
  logic [3:0] lost_reg;
  // Header image and emission
  logic [HDR_BYTES*8-1:0] hdr_img_reg;
  logic [3:0] word_idx_reg;
  logic busy_reg;
  logic drop_reg;
  // AXI handshake state
  logic aw_held_reg;
  logic w_held_reg;
  logic [5:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // Fill maximum and loss merge
  wire [2:0] fill_max = (fifo_fill > fill_reg) ? fifo_fill : fill_reg;
  wire [3:0] lost_now = {lost_tail, lost_mid, lost_head, lost_whole};
  // Accept end only while the previous header has drained
  wire finish = (state_reg == RHG_REC) && rec_end && !busy_reg;
  wire [7:0] status_byte = {range_reg | range_hit, fill_max, lost_reg | lost_now};
  wire [7:0] fmt_byte = rec_wide ? FMT_S32 : FMT_S16;
  // Header image assembled in listed order, byte 0 at bit 0
  wire [HDR_BYTES*8-1:0] hdr_img = {ts_reset_cnt, gpv_reg, rec_len_bytes, // R8 R7
                                    rec_start_ofs, trigger_time_ticks, // R6 R5
                                    sample_period, recnum_reg, serial_reg, // R4 R3 R2
                                    fmt_byte, rec_chan, unit_tag_byte_reg, // R16 R17 R18
                                    status_byte}; // R1 R21
  wire hdr_fire = hdr_valid && hdr_ready;
  wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid; // Both write beats in, no answer out
  wire [3:0] last_idx = 4'(HDR_WORDS - 1);

  // Record state and flag accumulation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= RHG_IDLE;
      range_reg <= 1'b0;
      fill_reg <= 3'h0;
      lost_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        RHG_IDLE: begin
          if (rec_start) begin
            state_reg <= RHG_REC;
            range_reg <= range_hit; // R22 R9
            fill_reg <= fifo_fill; // R22 R10
            lost_reg <= lost_now; // R22 R12
          end
        end
        RHG_REC: begin
          if (finish) begin
            state_reg <= RHG_IDLE;
          end else begin
            range_reg <= range_reg | range_hit; // R9
            fill_reg <= fill_max; // R11
            lost_reg <= lost_reg | lost_now; // R13 R14 R15
          end
        end
      endcase
    end
  end

  // Record counter since power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      recnum_reg <= 32'h00000000;
    end else if (finish) begin
      recnum_reg <= recnum_reg + 32'h00000001; // R3
    end
  end

  // Snapshot header at record end, then stream ten words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hdr_img_reg <= '0;
      busy_reg <= 1'b0;
      word_idx_reg <= 4'h0;
    end else if (finish) begin
      hdr_img_reg <= hdr_img; // R20
      busy_reg <= 1'b1;
      word_idx_reg <= 4'h0;
    end else if (hdr_fire) begin
      hdr_img_reg <= hdr_img_reg >> 32;
      word_idx_reg <= word_idx_reg + 4'h1;
      if (word_idx_reg == last_idx) begin
        busy_reg <= 1'b0; // R19
      end
    end
  end

  // Stream output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hdr_data <= 32'h00000000;
      hdr_valid <= 1'b0;
      hdr_last <= 1'b0;
    end else if (finish) begin
      hdr_data <= hdr_img[31:0];
      hdr_valid <= 1'b1;
      hdr_last <= 1'b0;
    end else if (hdr_fire) begin
      hdr_data <= hdr_img_reg[63:32];
      hdr_valid <= (word_idx_reg != last_idx);
      hdr_last <= (word_idx_reg == last_idx - 4'h1);
    end
  end

  // Ends refused while busy set the sticky drop flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_reg <= 1'b0;
    end else if (state_reg == RHG_REC && rec_end && busy_reg) begin
      drop_reg <= 1'b1;
    end else if (wr_go && awaddr_reg == ADR_STAT) begin
      drop_reg <= 1'b0;
    end
  end

  // AXI write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 6'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready is registered and low while a beat is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Write decode
  wire wr_ok = (awaddr_reg == ADR_CTRL) || (awaddr_reg == ADR_SERIAL) ||
               (awaddr_reg == ADR_GPV) || (awaddr_reg == ADR_STAT) ||
               (awaddr_reg == ADR_RECNUM);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Software register writes with byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_tag_byte_reg <= RST_TAG;
      serial_reg <= RST_SERIAL;
      gpv_reg <= RST_GPV;
    end else if (wr_go) begin
      if (awaddr_reg == ADR_CTRL && wstrb_reg[0]) begin
        unit_tag_byte_reg <= wdata_reg[7:0]; // R18
      end
      if (awaddr_reg == ADR_SERIAL) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            serial_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8]; // R2
          end
        end
      end
      if (awaddr_reg == ADR_GPV) begin
        if (wstrb_reg[0]) begin
          gpv_reg[7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          gpv_reg[15:8] <= wdata_reg[15:8];
        end
      end
    end
  end

  // Read mux
  wire [31:0] rd_mux = (s_axi_araddr == ADR_CTRL) ? {24'h000000, unit_tag_byte_reg} :
                       (s_axi_araddr == ADR_SERIAL) ? serial_reg :
                       (s_axi_araddr == ADR_RECNUM) ? recnum_reg :
                       (s_axi_araddr == ADR_GPV) ? {16'h0000, gpv_reg} :
                       (s_axi_araddr == ADR_STAT) ? {29'h00000000, drop_reg, busy_reg,
                                                     state_reg} : 32'h00000000;
  wire rd_ok = (s_axi_araddr == ADR_CTRL) || (s_axi_araddr == ADR_SERIAL) ||
               (s_axi_araddr == ADR_RECNUM) || (s_axi_araddr == ADR_GPV) ||
               (s_axi_araddr == ADR_STAT);

  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Assertions
  hdr_len_a: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    finish |=> busy_reg && word_idx_reg == 4'h0)
    else $error("header count not restarted");
  last_word_a: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    hdr_last |-> hdr_valid && word_idx_reg == last_idx)
    else $error("last flag at wrong word");
  first_bytes_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    finish |=> hdr_data[15:8] == $past(unit_tag_byte_reg) && hdr_data[23:16] == $past(rec_chan))
    else $error("leading bytes wrong");
  rec_count_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    finish |=> recnum_reg == $past(recnum_reg) + 32'h00000001)
    else $error("record count did not advance");
  fmt_code_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    finish |=> hdr_data[31:24] == ($past(rec_wide) ? FMT_S32 : FMT_S16))
    else $error("encoding byte wrong");
  range_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    state_reg == RHG_REC && range_hit && !finish |=> range_reg)
    else $error("range flag lost");
  fill_max_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    state_reg == RHG_REC && !finish && !rec_start |=> fill_reg >= $past(fill_reg))
    else $error("fill maximum dropped");
  lost_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    state_reg == RHG_REC && !finish && lost_now != 4'h0 |=> (lost_reg & $past(lost_now)) != 4'h0)
    else $error("loss flag not kept");
  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R22
    state_reg == RHG_IDLE && rec_start && !range_hit |=> !range_reg)
    else $error("range flag not cleared at start");
  stream_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_data))
    else $error("stream word changed while stalled");
  hdr_sent_c: cover property (@(posedge aclk) disable iff (!aresetn) hdr_last && hdr_ready);
  lost_rec_c: cover property (@(posedge aclk) disable iff (!aresetn) finish && lost_reg[0]);
  axi_wr_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_go);
  drop_c: cover property (@(posedge aclk) disable iff (!aresetn) drop_reg);

endmodule
